/* shared/srm_pkg.sv */
// package for the reference sync and window monitor block
package srm_pkg;
    // register addresses
    localparam logic [11:0] ADDR_MON_STATUS = 12'h140;  // monitor status
    localparam logic [11:0] ADDR_PIN_CFG    = 12'h146;  // general pin zero function
    localparam logic [11:0] ADDR_SYNC_CTRL  = 12'h147;  // mode and sync masks
    // status field positions
    localparam int STAT_ZERO_BIT = 7;                    // always reads zero
    localparam int STAT_DET_BIT  = 6;                    // edge seen, sticky
    localparam int STAT_ANY_BIT  = 5;                    // any window summary
    // control field positions
    localparam int CTRL_DEC_BIT      = 0;                // 1: decimation mode
    localparam int CTRL_DIV_MASK_BIT = 1;                // 1: divider reset masked
    localparam int CTRL_NCO_MASK_BIT = 2;                // 1: oscillator reset masked
    localparam int CTRL_RAMP_EN_BIT  = 3;                // 1: ramp reset allowed
    // reset values
    localparam logic [7:0] PIN_CFG_RESET   = 8'hFF;      // pin not used as reference
    localparam logic [7:0] PIN_CFG_AS_REF  = 8'h00;      // value selecting reference input
    localparam logic [7:0] SYNC_CTRL_RESET = 8'h08;      // bypass, no masks, ramp reset on
    localparam logic [7:0] STATUS_RESET    = 8'h00;
    // delay line sampling taps, offsets to sampling edge in ps
    localparam int NUM_TAPS    = 6;
    localparam int TAP_PS [NUM_TAPS] = '{-60, -20, 20, 60, 100, 140};
    localparam int CAPTURE_PS  = 60;                     // internal capture delay
    localparam int CAPTURE_TAP = 3;                      // tap at the capture delay
    localparam int NUM_WIN     = 5;                      // windows between taps
    // register access request
    typedef struct packed
    {
        logic        wr;                                 // write strobe
        logic        rd;                                 // read strobe
        logic [11:0] addr;                               // register address
        logic [7:0]  wdata;                              // write data
    } srm_reg_req_t;
    // sync reset pulses
    typedef struct packed
    {
        logic div_rst;                                   // decimation divider reset
        logic nco_rst;                                   // oscillator phase reset
        logic ramp_rst;                                  // ramp pattern reset
    } srm_sync_t;
endpackage

/* verilog/srm_sync_monitor.sv */
// reference pulse capture, sync resets and timing window monitor
//
// Behaviour
// RL1: capture reference at sampling edge plus 60ps
// RL2: source aligns reference rise to falling edge
// RL3: monitor transitions from -60ps to +140ps
// RL4: flag one: leads by 20 to 60ps
// RL5: flag two: within 20ps of edge
// RL6: flag three: lags by 20 to 60ps
// RL7: flag four: lags by 60 to 100ps
// RL8: flag five: lags by 100 to 140ps
// RL9: status refreshed on every reference rising edge
// RL10: edge seen bit sticky until host clears
// RL11: status layout: zero, det, any, windows
// RL12: decimation mode: pulse resets dividers and phase
// RL13: bypass mode: pulse resets ramp pattern
// RL14: bypass latency fixed without any pulse
// RL15: writing 0x00 to 0x146 selects reference
// RL16: a single reference pulse suffices
// RL17: masks select which blocks get reset
// RL18: any bit is OR of window flags
`timescale 1ns/10ps
`default_nettype none
module srm_sync_monitor #(
    parameter int DIV_W  = 16,                           // decimation divider width
    parameter int RAMP_W = 16                            // ramp pattern width
)(
    input  wire logic                 clk_i,             // sampling clock domain
    input  wire logic                 resetn_i,          // synchronous reset, low active
    input  wire logic [5:0]           ref_taps_i,        // reference seen at each delay tap
    input  wire srm_pkg::srm_reg_req_t reg_req_i,        // register access
    output logic [7:0]                reg_rdata_o,       // read data, one cycle after rd
    output logic                      ref_pin_sel_o,     // pin zero acts as reference
    output srm_pkg::srm_sync_t        sync_o,            // reset pulses to internal blocks
    output logic [DIV_W-1:0]          div_phase_o,       // decimation divider phase
    output logic [RAMP_W-1:0]         ramp_o             // ramp test pattern
);
    // register state
    logic [7:0]        status;                           // monitor status
    logic [7:0]        pin_cfg;                          // pin zero function
    logic [7:0]        ctrl;                             // mode and masks
    logic [7:0]        next_status;
    logic [7:0]        next_pin_cfg;
    logic [7:0]        next_ctrl;
    logic [7:0]        next_rdata;
    logic              next_pin_sel;                     // pin zero selected next cycle
    // capture state
    logic [5:0]        taps_prev;                        // taps from the previous cycle
    logic              ref_prev;                         // last captured level
    logic [5:0]        next_taps_prev;
    logic              next_ref_prev;
    // sync datapath state
    srm_pkg::srm_sync_t next_sync;
    logic [DIV_W-1:0]  next_div;
    logic [RAMP_W-1:0] next_ramp;
    // decoded helpers
    logic [5:0]        taps_eff;                         // taps gated by pin selection
    logic              ref_now;                          // level at the capture tap
    logic              rise_evt;                         // reference rising edge
    logic [4:0]        win_now;                          // window hits this cycle
    logic [4:0]        win_flags;                        // hits over the edge's two cycles
    logic              clr_det;                          // host clears edge seen bit

    // reference is only honoured while pin zero is configured for it
    always_comb
    begin
        taps_eff = pin_cfg == srm_pkg::PIN_CFG_AS_REF ? ref_taps_i : 6'h00; // [RL15]
        ref_now  = taps_eff[srm_pkg::CAPTURE_TAP];       // delayed capture point [RL1]
        rise_evt = ref_now & ~ref_prev;                  // one edge per pulse [RL16]
        // adjacent taps that disagree bracket the transition [RL3]
        win_now[0] = taps_eff[0] ^ taps_eff[1];          // [RL4]
        win_now[1] = taps_eff[1] ^ taps_eff[2];          // [RL5]
        win_now[2] = taps_eff[2] ^ taps_eff[3];          // [RL6]
        win_now[3] = taps_eff[3] ^ taps_eff[4];          // [RL7]
        win_now[4] = taps_eff[4] ^ taps_eff[5];          // [RL8]
        // a late transition straddles the capture tap one cycle before
        win_flags  = win_now | (taps_prev[0] ^ taps_prev[1] ? 5'h01 : 5'h00)
                   | {taps_prev[4] ^ taps_prev[5], taps_prev[3] ^ taps_prev[4],
                      taps_prev[2] ^ taps_prev[3], taps_prev[1] ^ taps_prev[2], 1'b0};
        clr_det    = reg_req_i.wr && reg_req_i.addr == srm_pkg::ADDR_MON_STATUS
                   && reg_req_i.wdata[srm_pkg::STAT_DET_BIT];
    end

    // next values of the registers and the read path
    always_comb
    begin
        next_status  = status;
        next_pin_cfg = pin_cfg;
        next_ctrl    = ctrl;
        next_rdata   = 8'h00;                            // unmapped reads zero
        // host write of one to the edge bit clears it
        if (clr_det)
        begin
            next_status[srm_pkg::STAT_DET_BIT] = 1'b0;   // [RL10]
        end
        // new edge refreshes every field, set beats clear
        if (rise_evt)
        begin
            next_status[4:0] = win_flags;                // [RL9]
            next_status[srm_pkg::STAT_ANY_BIT] = |win_flags; // [RL18]
            next_status[srm_pkg::STAT_DET_BIT] = 1'b1;   // [RL10]
        end
        next_status[srm_pkg::STAT_ZERO_BIT] = 1'b0;      // [RL11]
        // configuration writes
        if (reg_req_i.wr && reg_req_i.addr == srm_pkg::ADDR_PIN_CFG)
        begin
            next_pin_cfg = reg_req_i.wdata;              // [RL15]
        end
        if (reg_req_i.wr && reg_req_i.addr == srm_pkg::ADDR_SYNC_CTRL)
        begin
            next_ctrl = reg_req_i.wdata;
        end
        // pin acts as reference only while its function reads as reference
        next_pin_sel = next_pin_cfg == srm_pkg::PIN_CFG_AS_REF; // [RL15]
        // read mux
        if (reg_req_i.rd)
        begin
            case (reg_req_i.addr)
                srm_pkg::ADDR_MON_STATUS: next_rdata = status; // [RL11]
                srm_pkg::ADDR_PIN_CFG:    next_rdata = pin_cfg;
                srm_pkg::ADDR_SYNC_CTRL:  next_rdata = ctrl;
                default:                  next_rdata = 8'h00;
            endcase
        end
    end

    // register and read data flops
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            status      <= srm_pkg::STATUS_RESET;
            pin_cfg     <= srm_pkg::PIN_CFG_RESET;
            ctrl        <= srm_pkg::SYNC_CTRL_RESET;
            reg_rdata_o <= 8'h00;
        end
        else
        begin
            status      <= next_status;
            pin_cfg     <= next_pin_cfg;
            ctrl        <= next_ctrl;
            reg_rdata_o <= next_rdata;
        end
    end

    // capture history
    always_comb
    begin
        next_taps_prev = taps_eff;
        next_ref_prev  = ref_now;                        // [RL1]
    end

    // capture history flops
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            taps_prev <= 6'h00;
            ref_prev  <= 1'b0;
        end
        else
        begin
            taps_prev <= next_taps_prev;
            ref_prev  <= next_ref_prev;
        end
    end

    // sync pulses, divider phase and ramp pattern
    always_comb
    begin
        next_sync.div_rst  = rise_evt && ctrl[srm_pkg::CTRL_DEC_BIT]
                           && !ctrl[srm_pkg::CTRL_DIV_MASK_BIT];     // [RL12] [RL17]
        next_sync.nco_rst  = rise_evt && ctrl[srm_pkg::CTRL_DEC_BIT]
                           && !ctrl[srm_pkg::CTRL_NCO_MASK_BIT];     // [RL12] [RL17]
        next_sync.ramp_rst = rise_evt && !ctrl[srm_pkg::CTRL_DEC_BIT]
                           && ctrl[srm_pkg::CTRL_RAMP_EN_BIT];       // [RL13]
        // divider free runs, realigned to zero by the sync pulse
        next_div  = next_sync.div_rst ? '0 : div_phase_o + 1'b1;     // [RL12]
        // ramp steps every cycle; no pulse needed for fixed latency
        next_ramp = next_sync.ramp_rst ? '0 : ramp_o + 1'b1;         // [RL13] [RL14]
    end

    // sync datapath flops
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            sync_o      <= '0;
            div_phase_o <= '0;
            ramp_o      <= '0;
        end
        else
        begin
            sync_o      <= next_sync;
            div_phase_o <= next_div;
            ramp_o      <= next_ramp;
        end
    end

    // pin selection flag
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            ref_pin_sel_o <= 1'b0;
        end
        else
        begin
            ref_pin_sel_o <= next_pin_sel;
        end
    end

    // checks on the monitor and sync behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_rise_dec;
        rise_evt && ctrl[srm_pkg::CTRL_DEC_BIT] && !ctrl[srm_pkg::CTRL_DIV_MASK_BIT];
    endsequence
    sequence s_div_realigned;
        sync_o.div_rst && div_phase_o == '0 ##1 div_phase_o == 1;
    endsequence

    property p_det_set;
        rise_evt |=> status[srm_pkg::STAT_DET_BIT];
    endproperty
    a_det_set: assert property (p_det_set) else $error("edge bit not set"); // [RL10]

    property p_det_holds;
        status[srm_pkg::STAT_DET_BIT] && !clr_det |=> status[srm_pkg::STAT_DET_BIT];
    endproperty
    a_det_holds: assert property (p_det_holds) else $error("edge bit lost"); // [RL10]

    property p_any;
        status[srm_pkg::STAT_ANY_BIT] == |status[4:0];
    endproperty
    a_any: assert property (p_any) else $error("summary bit wrong"); // [RL18]

    property p_zero;
        !status[srm_pkg::STAT_ZERO_BIT];
    endproperty
    a_zero: assert property (p_zero) else $error("bit seven set"); // [RL11]

    property p_win_one;
        rise_evt && (taps_eff[0] ^ taps_eff[1]) |=> status[0];
    endproperty
    a_win_one: assert property (p_win_one) else $error("window one missed"); // [RL4]

    property p_win_four;
        rise_evt && (taps_prev[3] ^ taps_prev[4]) |=> status[3];
    endproperty
    a_win_four: assert property (p_win_four) else $error("window four missed"); // [RL7]

    property p_refresh;
        !rise_evt |=> $stable(status[5:0]);
    endproperty
    a_refresh: assert property (p_refresh) else $error("status changed without edge"); // [RL9]

    property p_div;
        s_rise_dec |=> s_div_realigned;
    endproperty
    a_div: assert property (p_div) else $error("divider not realigned"); // [RL12]

    property p_ramp;
        rise_evt && !ctrl[srm_pkg::CTRL_DEC_BIT] && ctrl[srm_pkg::CTRL_RAMP_EN_BIT]
            |=> ramp_o == '0 ##1 ramp_o == 1;
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp not reset"); // [RL13]

    property p_mask;
        rise_evt && ctrl[srm_pkg::CTRL_NCO_MASK_BIT] |=> !sync_o.nco_rst;
    endproperty
    a_mask: assert property (p_mask) else $error("masked reset fired"); // [RL17]

    property p_pin_cfg;
        reg_req_i.wr && reg_req_i.addr == srm_pkg::ADDR_PIN_CFG
            && reg_req_i.wdata == srm_pkg::PIN_CFG_AS_REF |=> ref_pin_sel_o;
    endproperty
    a_pin_cfg: assert property (p_pin_cfg) else $error("pin not selected"); // [RL15]

endmodule // srm_sync_monitor
`default_nettype wire

/* verif/srm_ref_gen.sv */
// model of the clock and reference generator driving the delay tap levels
`timescale 1ns/10ps
`default_nettype none
module srm_ref_gen #(
    parameter int HOLD = 4                  // cycles the pulse stays high after its launch cycle
)(
    input  wire logic       clk_i,          // sampling clock
    input  wire logic       go_i,           // launch one pulse
    input  wire logic [2:0] win_i,          // 0 aligned, 1..5 edge window
    output logic      [5:0] taps_o          // levels seen at the delay taps
);
    int cnt = 0;                            // cycles left in the pulse
    initial taps_o = 6'h00;
    // one pulse per launch, low otherwise
    always @(posedge clk_i)
    begin
        if (go_i)
        begin
            // aligned edge reaches every tap at once
            taps_o <= (win_i == 3'h0) ? 6'h3F : (6'h3F << win_i);
            cnt <= HOLD;
        end
        else if (cnt > 0)
        begin
            taps_o <= 6'h3F;
            cnt <= cnt - 1;
        end
        else
            taps_o <= 6'h00;
    end
endmodule // srm_ref_gen
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the reference sync and window monitor
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                  clk_i = 1'b0;    // sampling clock
    logic                  resetn_i = 1'b0; // reset, low active
    logic [5:0]            taps;            // tap levels from the model
    srm_pkg::srm_reg_req_t req = '0;        // register request
    logic [7:0]            rdata;           // register read data
    logic                  pin_sel;         // pin acts as reference
    srm_pkg::srm_sync_t    sync;            // sync reset pulses
    logic [15:0]           div_ph;          // divider phase
    logic [15:0]           ramp;            // ramp pattern
    logic [15:0]           ramp_old;        // earlier ramp sample
    logic [15:0]           div_old;         // earlier divider sample
    logic                  go = 1'b0;       // launch a pulse
    logic [2:0]            win = 3'h0;      // pulse edge window
    int failures = 0;
    int n_compared = 0;
    int n_div = 0;
    int n_nco = 0;
    int n_ramp = 0;
    int d0, c0, r0;
    // one case per row: control, window, status, expected pulse counts
    typedef struct
    {
        logic [7:0] ctrl;                   // sync control value
        logic [2:0] w;                      // edge window of the pulse
        logic [7:0] stat;                   // status expected afterwards
        int         d;                      // divider resets expected
        int         n;                      // phase resets expected
        int         r;                      // ramp resets expected
    } srm_row_t;
    srm_row_t rows [6] = '{
        '{8'h08, 3'h0, 8'h40, 0, 0, 1},     // aligned edge, bypass ramp reset
        '{8'h08, 3'h1, 8'h61, 0, 0, 1},
        '{8'h00, 3'h2, 8'h62, 0, 0, 0},
        '{8'h01, 3'h3, 8'h64, 1, 1, 0},
        '{8'h03, 3'h4, 8'h68, 0, 1, 0},
        '{8'h05, 3'h5, 8'h70, 1, 0, 0}};

    srm_sync_monitor uut (
        .clk_i         (clk_i),
        .resetn_i      (resetn_i),
        .ref_taps_i    (taps),
        .reg_req_i     (req),
        .reg_rdata_o   (rdata),
        .ref_pin_sel_o (pin_sel),
        .sync_o        (sync),
        .div_phase_o   (div_ph),
        .ramp_o        (ramp)
    );
    srm_ref_gen gen (.clk_i(clk_i), .go_i(go), .win_i(win), .taps_o(taps));

    // clock generator
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    // count sync pulses by kind, mid cycle while each pulse stands
    always @(negedge clk_i)
    begin
        if (sync.div_rst === 1'b1)
        begin
            n_div++;
            check(div_ph, 16'h0000, "divider at sync");
        end
        if (sync.nco_rst === 1'b1) n_nco++;
        if (sync.ramp_rst === 1'b1)
        begin
            n_ramp++;
            check(ramp, 16'h0000, "ramp at sync");
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk_i);
        req.wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_i);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk_i);
        req.rd <= 1'b0;
        @(negedge clk_i);
        check({8'h00, rdata}, {8'h00, exp}, what);
    endtask
    task automatic fire(input logic [2:0] w);
        @(posedge clk_i);
        go <= 1'b1;
        win <= w;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask
    task automatic test_done();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog against a hang
    initial
    begin
        #15000;
        failures++;
        $display("BAD %0t timeout", $time);
        test_done();
    end
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(negedge clk_i);
        check({15'h0000, pin_sel}, 16'h0000, "pin select reset");
        check(ramp, 16'h0000, "ramp reset");
        check(div_ph, 16'h0000, "divider reset");
        reg_rd(srm_pkg::ADDR_MON_STATUS, srm_pkg::STATUS_RESET, "status reset");
        reg_rd(srm_pkg::ADDR_PIN_CFG, srm_pkg::PIN_CFG_RESET, "pin cfg reset");
        reg_rd(srm_pkg::ADDR_SYNC_CTRL, srm_pkg::SYNC_CTRL_RESET, "ctrl reset");
        reg_rd(12'h150, 8'h00, "unmapped read");
        reg_wr(12'h150, 8'hFF);
        fire(3'h1);
        reg_rd(srm_pkg::ADDR_MON_STATUS, 8'h00, "pulse while pin off");
        reg_wr(srm_pkg::ADDR_PIN_CFG, srm_pkg::PIN_CFG_AS_REF);
        @(negedge clk_i);
        check({15'h0000, pin_sel}, 16'h0001, "pin select");
        ramp_old = ramp;
        div_old = div_ph;
        @(negedge clk_i);
        check(ramp, ramp_old + 16'h0001, "ramp runs free");
        check(div_ph, div_old + 16'h0001, "divider runs free");
        // each row: set mode, clear edge bit, one pulse, read status
        foreach (rows[i])
        begin
            reg_wr(srm_pkg::ADDR_SYNC_CTRL, rows[i].ctrl);
            reg_wr(srm_pkg::ADDR_MON_STATUS, 8'h40);
            d0 = n_div;
            c0 = n_nco;
            r0 = n_ramp;
            fire(rows[i].w);
            reg_rd(srm_pkg::ADDR_MON_STATUS, rows[i].stat, "status");
            check(16'(n_div - d0), 16'(rows[i].d), "divider resets");
            check(16'(n_nco - c0), 16'(rows[i].n), "phase resets");
            check(16'(n_ramp - r0), 16'(rows[i].r), "ramp resets");
        end
        // host clears the sticky edge bit, windows stay
        reg_wr(srm_pkg::ADDR_MON_STATUS, 8'h40);
        reg_rd(srm_pkg::ADDR_MON_STATUS, 8'h30, "edge bit cleared");
        // edge and host clear sampled at one edge: the edge wins
        fork
            fire(3'h0);
            begin
                @(posedge clk_i);
                reg_wr(srm_pkg::ADDR_MON_STATUS, 8'h40);
            end
        join
        reg_rd(srm_pkg::ADDR_MON_STATUS, 8'h40, "set beats clear");
        test_done();
    end
endmodule // tb_top
`default_nettype wire
